// *** lic_pkg.sv ***
/*
  lic_pkg: shared constants, types and helper functions for the
  lamp indicator control block.
  assumes a 50 MHz pclk and a 32-bit APB register port.
*/
package lic_pkg;

  // clock and the millisecond time base
  localparam int LIC_CLK_NS = 20;
  localparam int LIC_MS_NS  = 1000000;
  localparam int LIC_MS_CYC = LIC_MS_NS / LIC_CLK_NS;

  // register indices; byte address is four times the index
  localparam logic [7:0] LIC_IDX_L0CTL  = 8'h10;
  localparam logic [7:0] LIC_IDX_POLMIX = 8'h11;
  localparam logic [7:0] LIC_IDX_TIMER  = 8'h12;
  localparam logic [7:0] LIC_IDX_STAT   = 8'h13;

  // field positions
  localparam int LIC_MIXHI_LSB  = 12;
  localparam int LIC_MIXLO_LSB  = 8;
  localparam int LIC_FRCINT_BIT = 15;
  localparam int LIC_STRCH_LSB  = 12;
  localparam int LIC_INTPOL_BIT = 11;
  localparam int LIC_BLINK_LSB  = 8;
  localparam int LIC_SPDOFF_LSB = 2;
  localparam int LIC_SPDON_LSB  = 0;

  // values after reset
  localparam logic [2:0] LIC_STRCH_RST = 3'h4;
  localparam logic [1:0] LIC_SPD_RST   = 2'h1;
  localparam logic [2:0] LIC_BLINK_RST = 3'h1;
  localparam logic [3:0] LIC_MIX_RST   = 4'h4;
  localparam logic [3:0] LIC_L0_RST    = 4'he;
  localparam logic [1:0] LIC_STRAP_WAIT = 2'h2;

  // lamp-0 control codes
  localparam logic [3:0] LIC_L0_LINK   = 4'h0;
  localparam logic [3:0] LIC_L0_LNKACT = 4'h1;
  localparam logic [3:0] LIC_L0_SPEED  = 4'h2;
  localparam logic [3:0] LIC_L0_ACT    = 4'h3;
  localparam logic [3:0] LIC_L0_BLKACT = 4'h4;
  localparam logic [3:0] LIC_L0_TX     = 4'h5;
  localparam logic [3:0] LIC_L0_COPPER = 4'h6;
  localparam logic [3:0] LIC_L0_GIG    = 4'h7;
  localparam logic [3:0] LIC_L0_OFF    = 4'h8;
  localparam logic [3:0] LIC_L0_ON     = 4'h9;
  localparam logic [3:0] LIC_L0_HIZ    = 4'ha;
  localparam logic [3:0] LIC_L0_BLINK  = 4'hb;
  localparam logic [1:0] LIC_SPD_1000  = 2'h2;

  // status from the phy core, same clock
  typedef struct packed {
    logic       link;
    logic [1:0] speed;    // 00 10M, 01 100M, 10 1000M
    logic       act;
    logic       tx;
    logic       copper;
  } lic_phy_stat_type;

  typedef enum logic [1:0] {SB_IDLE, SB_ON, SB_OFF, SB_GAP}
    lic_sb_state_type;

  typedef struct packed {
    logic [11:0] cnt;
  } lic_tmr_type;

  typedef struct packed {
    logic [15:0]      ms_cnt;
    logic             tick;
    logic [1:0]       strap_cnt;
    logic             strap_done;
    logic [3:0]       l0_ctl;
    logic [3:0]       mix_hi;
    logic [3:0]       mix_lo;
    logic [7:0]       pol;
    logic             frc_int;
    logic [2:0]       stretch;
    logic             int_pol;
    logic [2:0]       blink;
    logic [1:0]       spd_off;
    logic [1:0]       spd_on;
    logic             blink_ph;
    lic_sb_state_type sb;
    logic [1:0]       sb_cnt;
    logic [2:0]       slot;
    logic [3:0]       lamp_out;
    logic [3:0]       lamp_oe_n;
    logic             irq_pin;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
  } lic_state_type;

  // speed-blink period in ms
  function automatic logic [11:0] lic_spd_ms(input logic [1:0] c);
    case (c)
      2'h0:    lic_spd_ms = 12'd84;
      2'h1:    lic_spd_ms = 12'd170;
      2'h2:    lic_spd_ms = 12'd340;
      default: lic_spd_ms = 12'd670;
    endcase
  endfunction

  // blink period in ms; reserved codes run at the slowest rate
  function automatic logic [11:0] lic_blink_ms(input logic [2:0] c);
    case (c)
      3'h0:    lic_blink_ms = 12'd42;
      3'h1:    lic_blink_ms = 12'd84;
      3'h2:    lic_blink_ms = 12'd170;
      3'h3:    lic_blink_ms = 12'd340;
      default: lic_blink_ms = 12'd670;
    endcase
  endfunction

  // stretch window in ms, lower end of each printed range
  function automatic logic [11:0] lic_strch_ms(input logic [2:0] c);
    case (c)
      3'h0:    lic_strch_ms = 12'd0;
      3'h1:    lic_strch_ms = 12'd21;
      3'h2:    lic_strch_ms = 12'd42;
      3'h3:    lic_strch_ms = 12'd84;
      3'h4:    lic_strch_ms = 12'd170;
      3'h5:    lic_strch_ms = 12'd340;
      3'h6:    lic_strch_ms = 12'd670;
      default: lic_strch_ms = 12'd1300;
    endcase
  endfunction

endpackage

// *** lic_sync.sv ***
/*
  lic_sync: two-stage synchroniser for pin levels.
  assumes d is a slow level from outside the pclk domain.
*/
`timescale 1ns/100ps
module lic_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,     // clock
  input  wire logic         presetn,  // async reset, active low
  input  wire logic [W-1:0] d,        // pin level
  output logic      [W-1:0] q         // synchronised level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lic_sync_st_type;

  lic_sync_st_type st_ff;
  lic_sync_st_type nxt_st;

  // s1 feeds only s2
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule

// *** lic_timer.sv ***
/*
  lic_timer: millisecond down-counter with load and expiry pulse.
  assumes tick is a one-cycle pulse once per millisecond.
*/
`timescale 1ns/100ps
module lic_timer
  import lic_pkg::*;
(
  input  wire logic        pclk,     // clock
  input  wire logic        presetn,  // async reset, active low
  input  wire logic        tick,     // 1 ms pulse
  input  wire logic        load,     // start a new count
  input  wire logic [11:0] load_ms,  // count in ms
  output logic             busy,     // counting
  output logic             done      // last ms elapsed, one cycle
);
  lic_tmr_type st_ff;
  lic_tmr_type nxt_st;

  // load wins over the running count
  always_comb begin
    nxt_st = st_ff;
    if (load) begin
      nxt_st.cnt = load_ms;
    end else if (tick && (st_ff.cnt != 12'h000)) begin
      nxt_st.cnt = st_ff.cnt - 12'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy = (st_ff.cnt != 12'h000);
  assign done = tick && (st_ff.cnt == 12'h001);
endmodule

// *** lic_led_ctrl.sv ***
/*
  lic_led_ctrl: status lamp drivers, lamp timers and interrupt pin
  control of the phy, with its registers on an APB slave port.
  assumes phy status and irq_req come from logic on pclk; straps are
  pins and are synchronised, then captured once after reset release.
*/
// Local design decision: register access over APB.
// Summary of operation
// - code 0 lights on link; code 1 lights on link, blinks on activity.
// - code 2 blinks groups of three, two, one by speed; none without link.
// - codes 3,4,5: on for activity, blink for activity, on for transmit.
// - code 6 lights for copper link, code 7 only for 1000 Mb/s link.
// - codes 8,9 force off/on, 10 floats the pin, 11 blinks always.
// - codes 12 to 15 select dual-lamp modes one to four with lamp 1.
// - lamp-0 code loads from strap: 00 gives 1110, 01, 10 and 11 give 0111.
// - mix_lo sets the lamp-1 share of the pair in eighths; 1000 means full; mix_hi has no effect.
// - mix fields load 0100 for strap 00/01, 1000 for strap 10/11.
// - polarity 00 low-on, 01 high-on, 10 low-on float-off, 11 high-on float-off.
// - polarity of lamps 3..0 in bits 7:6..1:0, zero after reset.
// - timer bit 15 forces the interrupt pin asserted.
// - stretch code 0 none, 1..7 from 21 ms doubling; resets to 100.
// - interrupt polarity bit loads its strap; 0 active high, 1 low.
// - blink rate codes 0..4 give 42 to 670 ms periods.
// - blink rate loads 000 for strap 01, otherwise 001.
// - speed on/off periods 84 to 670 ms; both reset to 01.
`timescale 1ns/100ps
module lic_led_ctrl
  import lic_pkg::*;
#(
  parameter int MS_CYCLES = LIC_MS_CYC
) (
  input  wire logic             pclk,               // 50 MHz clock
  input  wire logic             presetn,            // async reset, low
  input  wire logic             psel,               // apb select
  input  wire logic             penable,            // apb enable
  input  wire logic             pwrite,             // apb write
  input  wire logic [7:0]       paddr,              // apb byte address
  input  wire logic [31:0]      pwdata,             // apb write data
  output logic      [31:0]      prdata,             // apb read data
  output logic                  pready,             // apb ready
  output logic                  pslverr,            // apb error
  input  wire lic_phy_stat_type phy_stat,           // link status
  input  wire logic             irq_req,            // phy interrupt
  input  wire logic [3:1]       lamp_ext,           // lamps 1-3 states
  input  wire logic [1:0]       lamp_config_strap,  // lamp strap pins
  input  wire logic             irq_polarity_strap, // irq strap pin
  output logic      [3:0]       lamp_out,           // lamp pin levels
  output logic      [3:0]       lamp_oe_n,          // low drives pin
  output logic                  phy_irq_out         // interrupt pin
);

  lic_state_type st_ff;
  lic_state_type nxt_st;

  logic [2:0]  strap_s;
  logic [7:0]  idx;
  logic        hit;
  logic        wr_en;
  logic        blink_busy;
  logic        blink_done;
  logic        act_busy;
  logic        tx_busy;
  logic        sb_busy;
  logic        sb_done;
  logic        sb_load;
  logic [11:0] sb_ms;
  logic        act_st;
  logic        tx_st;
  logic [1:0]  sb_groups;
  logic        l0_on;
  logic        l1_on;
  logic        dual;
  logic        dual_cond;
  logic [3:0]  on;
  logic [1:0]  pc;
  logic [31:0] rd;

  // strap pins are asynchronous levels
  lic_sync #(
    .W (3)
  ) u_strap_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({irq_polarity_strap, lamp_config_strap}),
    .q       (strap_s)
  );

  // blink phase timer, half a blink period per phase
  lic_timer u_blink_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (st_ff.tick),
    .load    (!blink_busy),
    .load_ms (lic_blink_ms(st_ff.blink) >> 1),
    .busy    (blink_busy),
    .done    (blink_done)
  );

  // stretch timers
  // each new activity restarts the window
  lic_timer u_act_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (st_ff.tick),
    .load    (phy_stat.act),
    .load_ms (lic_strch_ms(st_ff.stretch)),
    .busy    (act_busy),
    .done    ()
  );

  lic_timer u_tx_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (st_ff.tick),
    .load    (phy_stat.tx),
    .load_ms (lic_strch_ms(st_ff.stretch)),
    .busy    (tx_busy),
    .done    ()
  );

  // speed-blink on/off/gap timer
  lic_timer u_sb_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (st_ff.tick),
    .load    (sb_load),
    .load_ms (sb_ms),
    .busy    (sb_busy),
    .done    (sb_done)
  );

  // stretched activity; code 0 loads zero so nothing is held
  assign act_st = phy_stat.act || act_busy;
  assign tx_st  = phy_stat.tx || tx_busy;

  // blinks per group: one, two or three by speed
  assign sb_groups = (phy_stat.speed == 2'h3) ? LIC_SPD_1000
                                              : phy_stat.speed;

  // apb decode: word aligned, index from the upper address bits
  assign idx   = {2'b00, paddr[7:2]};
  assign hit   = (paddr[1:0] == 2'b00) &&
                 (idx >= LIC_IDX_L0CTL) && (idx <= LIC_IDX_STAT);
  assign wr_en = psel && penable && pwrite && st_ff.pready &&
                 hit && st_ff.strap_done;

  // field layout
  // register read mux; reserved bits read zero
  always_comb begin
    rd = 32'h0000_0000;
    case (idx)
      LIC_IDX_L0CTL:  rd[3:0] = st_ff.l0_ctl;
      LIC_IDX_POLMIX: rd[15:0] = {st_ff.mix_hi, st_ff.mix_lo, st_ff.pol};
      LIC_IDX_TIMER: begin
        rd[LIC_FRCINT_BIT]               = st_ff.frc_int;
        rd[LIC_STRCH_LSB +: 3]           = st_ff.stretch;
        rd[LIC_INTPOL_BIT]               = st_ff.int_pol;
        rd[LIC_BLINK_LSB +: 3]           = st_ff.blink;
        rd[LIC_SPDOFF_LSB +: 2]          = st_ff.spd_off;
        rd[LIC_SPDON_LSB +: 2]           = st_ff.spd_on;
      end
      LIC_IDX_STAT: begin
        rd[3:0]   = st_ff.lamp_out;
        rd[7:4]   = st_ff.lamp_oe_n;
        rd[8]     = st_ff.irq_pin;
        rd[9]     = l0_on;
        rd[10]    = phy_stat.link;
        rd[13:11] = strap_s;
        rd[14]    = st_ff.strap_done;
      end
      default: rd = 32'h0000_0000;
    endcase
  end

  // lamp-0 function, speed blinker and next state
  always_comb begin
    nxt_st    = st_ff;
    sb_load   = 1'b0;
    sb_ms     = lic_spd_ms(st_ff.spd_on);
    l0_on     = 1'b0;
    l1_on     = lamp_ext[1];
    dual      = st_ff.l0_ctl[3] && st_ff.l0_ctl[2];
    dual_cond = 1'b0;
    on        = 4'h0;
    pc        = 2'h0;

    // millisecond tick
    nxt_st.tick = 1'b0;
    if (st_ff.ms_cnt == 16'(MS_CYCLES - 1)) begin
      nxt_st.ms_cnt = 16'h0000;
      nxt_st.tick   = 1'b1;
    end else begin
      nxt_st.ms_cnt = st_ff.ms_cnt + 16'h0001;
    end

    // pwm slot for lamp mixing, eight slots per round
    nxt_st.slot = st_ff.slot + 3'h1;

    if (blink_done) begin
      nxt_st.blink_ph = !st_ff.blink_ph;
    end

    // strap capture once the synchroniser has settled
    if (!st_ff.strap_done) begin
      nxt_st.strap_cnt = st_ff.strap_cnt + 2'h1;
      if (st_ff.strap_cnt == LIC_STRAP_WAIT) begin
        nxt_st.strap_done = 1'b1;
        nxt_st.l0_ctl = (strap_s[1:0] == 2'b00) ? LIC_L0_RST
                                                : LIC_L0_GIG;
        nxt_st.mix_hi = strap_s[1] ? 4'h8 : LIC_MIX_RST;
        nxt_st.mix_lo = strap_s[1] ? 4'h8 : LIC_MIX_RST;
        nxt_st.blink = (strap_s[1:0] == 2'b01) ? 3'h0 : LIC_BLINK_RST;
        nxt_st.int_pol = strap_s[2];
      end
    end

    // apb: answer in the first access cycle
    nxt_st.pready = psel && !penable;
    if (psel && !penable) begin
      nxt_st.prdata  = hit ? rd : 32'h0000_0000;
      nxt_st.pslverr = !hit;
    end
    if (wr_en) begin
      case (idx)
        LIC_IDX_L0CTL:  nxt_st.l0_ctl = pwdata[3:0];
        LIC_IDX_POLMIX: begin
          nxt_st.mix_hi = pwdata[LIC_MIXHI_LSB +: 4];
          nxt_st.mix_lo = pwdata[LIC_MIXLO_LSB +: 4];
          nxt_st.pol    = pwdata[7:0];
        end
        LIC_IDX_TIMER: begin
          nxt_st.frc_int = pwdata[LIC_FRCINT_BIT];
          nxt_st.stretch = pwdata[LIC_STRCH_LSB +: 3];
          nxt_st.int_pol = pwdata[LIC_INTPOL_BIT];
          nxt_st.blink   = pwdata[LIC_BLINK_LSB +: 3];
          nxt_st.spd_off = pwdata[LIC_SPDOFF_LSB +: 2];
          nxt_st.spd_on  = pwdata[LIC_SPDON_LSB +: 2];
        end
        default: nxt_st.l0_ctl = st_ff.l0_ctl;
      endcase
    end

    // speed blink sequence
    // a group ends with a double off period
    case (st_ff.sb)
      SB_IDLE: begin
        if (phy_stat.link) begin
          nxt_st.sb     = SB_ON;
          nxt_st.sb_cnt = 2'h0;
          sb_load       = 1'b1;
        end
      end
      SB_ON: begin
        if (sb_done) begin
          sb_load = 1'b1;
          sb_ms   = lic_spd_ms(st_ff.spd_off);
          if (st_ff.sb_cnt == sb_groups) begin
            nxt_st.sb = SB_GAP;
            sb_ms     = lic_spd_ms(st_ff.spd_off) << 1;
          end else begin
            nxt_st.sb = SB_OFF;
          end
        end
      end
      SB_OFF: begin
        if (sb_done) begin
          nxt_st.sb     = SB_ON;
          nxt_st.sb_cnt = st_ff.sb_cnt + 2'h1;
          sb_load       = 1'b1;
        end
      end
      SB_GAP: begin
        if (sb_done) begin
          nxt_st.sb     = SB_ON;
          nxt_st.sb_cnt = 2'h0;
          sb_load       = 1'b1;
        end
      end
      default: nxt_st.sb = SB_IDLE;
    endcase
    if (!phy_stat.link) begin
      nxt_st.sb = SB_IDLE;
    end

    // lamp-0 function by control code
    case (st_ff.l0_ctl)
      LIC_L0_LINK:   l0_on = phy_stat.link;
      LIC_L0_LNKACT: l0_on = phy_stat.link &&
                             (!act_st || st_ff.blink_ph);
      LIC_L0_SPEED:  l0_on = phy_stat.link && (st_ff.sb == SB_ON);
      LIC_L0_ACT:    l0_on = act_st;
      LIC_L0_BLKACT: l0_on = act_st && st_ff.blink_ph;
      LIC_L0_TX:     l0_on = tx_st;
      LIC_L0_COPPER: l0_on = phy_stat.link && phy_stat.copper;
      LIC_L0_GIG:    l0_on = phy_stat.link &&
                             (phy_stat.speed == LIC_SPD_1000);
      LIC_L0_OFF:    l0_on = 1'b0;
      LIC_L0_ON:     l0_on = 1'b1;
      LIC_L0_HIZ:    l0_on = 1'b0;
      LIC_L0_BLINK:  l0_on = st_ff.blink_ph;
      4'hc:    dual_cond = phy_stat.link;
      4'hd:    dual_cond = phy_stat.link &&
                           (!act_st || st_ff.blink_ph);
      4'he:    dual_cond = act_st;
      default: dual_cond = st_ff.blink_ph;
    endcase

    // mix share in eighths
    // codes above 8 saturate at a full share
    if (dual) begin
      l1_on = dual_cond && ({1'b0, st_ff.slot} < st_ff.mix_lo);
      l0_on = dual_cond && !({1'b0, st_ff.slot} < st_ff.mix_lo);
    end

    on = {lamp_ext[3:2], l1_on, l0_on};
    for (int i = 0; i < 4; i++) begin
      pc                  = st_ff.pol[2*i +: 2];
      nxt_st.lamp_out[i]  = on[i] ? pc[0] : !pc[0];
      nxt_st.lamp_oe_n[i] = !on[i] && pc[1];
    end
    if (st_ff.l0_ctl == LIC_L0_HIZ) begin
      nxt_st.lamp_oe_n[0] = 1'b1;
    end

    nxt_st.irq_pin = (irq_req || st_ff.frc_int) ^ st_ff.int_pol;
  end

  // state register; lamps idle off-high until the first update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff          <= '0;
      st_ff.stretch  <= LIC_STRCH_RST;
      st_ff.spd_off  <= LIC_SPD_RST;
      st_ff.spd_on   <= LIC_SPD_RST;
      st_ff.blink    <= LIC_BLINK_RST;
      st_ff.l0_ctl   <= LIC_L0_RST;
      st_ff.mix_hi   <= LIC_MIX_RST;
      st_ff.mix_lo   <= LIC_MIX_RST;
      st_ff.lamp_out <= 4'hf;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign prdata      = st_ff.prdata;
  assign pready      = st_ff.pready;
  assign pslverr     = st_ff.pslverr;
  assign lamp_out    = st_ff.lamp_out;
  assign lamp_oe_n   = st_ff.lamp_oe_n;
  assign phy_irq_out = st_ff.irq_pin;
endmodule

// *** lic_led_ctrl_sva.sv ***
/*
  lic_led_ctrl_sva: bus and pin checks on the lamp block ports.
  assumes registers are written only after strap capture.
*/
`timescale 1ns/100ps
module lic_led_ctrl_sva
  import lic_pkg::*;
#(
  parameter int MS_CYCLES = LIC_MS_CYC
) (
  input logic        pclk,        // clock
  input logic        presetn,     // reset, low
  input logic        psel,        // apb select
  input logic        penable,     // apb enable
  input logic        pwrite,      // apb write
  input logic [7:0]  paddr,       // apb address
  input logic [31:0] pwdata,      // apb write data
  input logic [31:0] prdata,      // apb read data
  input logic        pready,      // apb ready
  input logic        pslverr,     // apb error
  input logic        irq_req,     // phy interrupt
  input logic [3:1]  lamp_ext,    // lamp states
  input logic [3:0]  lamp_out,    // pin levels
  input logic [3:0]  lamp_oe_n,   // pin enables
  input logic        phy_irq_out  // interrupt pin
);
  logic       wr;
  logic       frc_ff;
  logic [7:0] pol_ff;
  logic [1:0] up_ff;

  assign wr = psel && penable && pready && pwrite;

  // shadow of force and polarity bits; up_ff hides pre-reset history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frc_ff <= 1'b0;
      pol_ff <= 8'h00;
      up_ff  <= 2'h0;
    end else begin
      if (wr && paddr == 8'h48) frc_ff <= pwdata[15];
      if (wr && paddr == 8'h44) pol_ff <= pwdata[7:0];
      if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_pready_one;
    psel && !penable |=> pready;
  endproperty
  a_pready_one: assert property (p_pready_one)
    else $error("no ready after setup");

  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("ready held too long");

  property p_err;
    psel && !penable && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err)
    else $error("unaligned access not refused");

  property p_rsvd;
    pready && !pwrite && paddr == 8'h48 |->
      prdata[31:16] == 16'h0 && prdata[7:4] == 4'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved timer bits read nonzero");

  property p_irq_follow;
    $changed(irq_req) && !frc_ff && !$past(wr) |=> $changed(phy_irq_out);
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("interrupt pin ignored request");

  property p_irq_force;
    frc_ff && !$past(wr) |=> $stable(phy_irq_out);
  endproperty
  a_irq_force: assert property (p_irq_force)
    else $error("forced interrupt pin moved");

  property p_lamp_lvl;
    up_ff == 2'h3 |-> lamp_out[3:2] ==
      ($past(lamp_ext[3:2]) ~^ {$past(pol_ff[6]), $past(pol_ff[4])});
  endproperty
  a_lamp_lvl: assert property (p_lamp_lvl)
    else $error("lamp level wrong");

  property p_lamp_oe;
    up_ff == 2'h3 |-> lamp_oe_n[3:2] ==
      (~$past(lamp_ext[3:2]) & {$past(pol_ff[7]), $past(pol_ff[5])});
  endproperty
  a_lamp_oe: assert property (p_lamp_oe)
    else $error("lamp enable wrong");

  c_force: cover property (frc_ff && phy_irq_out);
  c_float: cover property (lamp_oe_n[3]);
  c_err: cover property (pslverr);
endmodule

bind lic_led_ctrl lic_led_ctrl_sva #(.MS_CYCLES(MS_CYCLES)) i_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
  .lamp_ext(lamp_ext), .lamp_out(lamp_out), .lamp_oe_n(lamp_oe_n),
  .phy_irq_out(phy_irq_out)
);

// *** lic_lamp_board.sv ***
/*
  lic_lamp_board: lamps on the board behind the four lamp pins.
  assumes each lamp glows when its pin sits at its active level.
*/
`timescale 1ns/100ps
module lic_lamp_board (
  input  logic [3:0] lamp_out,   // pin level from block
  input  logic [3:0] lamp_oe_n,  // low while driven
  input  logic [3:0] act_hi,     // lamp glows on high
  output logic [3:0] pin,        // wire level
  output logic [3:0] lit         // lamp glows
);
  // a floating pin is pulled to the off level, so its lamp stays dark
  assign pin = (lamp_out & ~lamp_oe_n) | (~act_hi & lamp_oe_n);
  assign lit = ~(pin ^ act_hi);
endmodule

// *** tb.sv ***
/*
  tb: self-checking bench for lic_led_ctrl with a board lamp model.
  assumes a 1 ms base shortened to MS cycles.
*/
`timescale 1ns/100ps
module tb;
  import lic_pkg::*;
  localparam int MS  = 10;
  localparam int SPD = 84 * MS;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic irq_req, irq_polarity_strap, phy_irq_out;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [3:1]  lamp_ext;
  logic [1:0]  lamp_config_strap;
  logic [3:0]  lamp_out, lamp_oe_n, pin, lit;
  lic_phy_stat_type phy_stat, st;
  int errors, n_checks, cnt;
  int cyc = 0;

  lic_led_ctrl #(.MS_CYCLES(MS)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phy_stat(phy_stat),
    .irq_req(irq_req), .lamp_ext(lamp_ext),
    .lamp_config_strap(lamp_config_strap),
    .irq_polarity_strap(irq_polarity_strap), .lamp_out(lamp_out),
    .lamp_oe_n(lamp_oe_n), .phy_irq_out(phy_irq_out)
  );
  lic_lamp_board i_board (
    .lamp_out(lamp_out), .lamp_oe_n(lamp_oe_n), .act_hi(4'h1),
    .pin(pin), .lit(lit)
  );

  // clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // one transfer; an idle edge after it keeps strobes single-driven
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic do_reset(input logic [1:0] s);
    presetn <= 1'b0;
    lamp_config_strap <= s;
    irq_polarity_strap <= s[0];
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask

  task automatic count(input int n);
    logic last;
    cnt = 0;
    last = lit[0];
    repeat (n) begin
      @(posedge pclk);
      if (lit[0] && !last) cnt++;
      last = lit[0];
    end
  endtask

  function automatic logic [31:0] exp_tmr(input int s);
    exp_tmr = 32'h4005 | (32'(s % 2) << 11) | ((s != 1) ? 32'h100 : 32'h0);
  endfunction

  function automatic logic [3:0] exp_pins(input logic [3:2] on,
                                          input logic [7:0] p);
    exp_pins = {on[3] ~^ p[6], on[2] ~^ p[4], ~on[3] & p[7], ~on[2] & p[5]};
  endfunction

  function automatic logic l0_on(input int c, input lic_phy_stat_type s);
    case (c)
      0, 1:    l0_on = s.link;
      3, 4:    l0_on = s.act;
      5:       l0_on = s.tx;
      6:       l0_on = s.link & s.copper;
      7:       l0_on = s.link && s.speed == LIC_SPD_1000;
      9:       l0_on = 1'b1;
      default: l0_on = 1'b0;
    endcase
  endfunction

  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, irq_req, lamp_ext} = '0;
    {presetn, lamp_config_strap, irq_polarity_strap} = '0;
    phy_stat = '0;
    errors = 0;
    n_checks = 0;
    void'($urandom(32'h5ac16bd2));
    @(posedge pclk);
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1:0]);
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, (s == 0) ? 32'he : 32'h7);
      apb(1'b0, 8'h44, 32'h0);
      chk(rd, s[1] ? 32'h8800 : 32'h4400);
      apb(1'b0, 8'h48, 32'h0);
      chk(rd, exp_tmr(s));
      chk(phy_irq_out, s % 2);
    end
    // unmapped and unaligned places are refused
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, i ? 8'h41 : 8'h80, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
    end
    // random polarity and mix with random lamp states
    repeat (8) begin
      v = {16'h0, 4'($urandom_range(8)), 4'($urandom_range(8)), 8'($urandom)};
      apb(1'b1, 8'h44, v);
      lamp_ext <= 3'($urandom);
      repeat (3) @(posedge pclk);
      chk({lamp_out[3:2], lamp_oe_n[3:2]}, exp_pins(lamp_ext[3:2], v[7:0]));
      apb(1'b0, 8'h44, 32'h0);
      chk(rd, v);
    end
    apb(1'b1, 8'h48, 32'h0);
    apb(1'b1, 8'h44, 32'h1);
    for (int c = 0; c < 11; c++) begin
      if (c == 2) continue;
      apb(1'b1, 8'h40, c);
      repeat (4) begin
        st = lic_phy_stat_type'($urandom);
        st.speed = 2'($urandom_range(2));
        if (c == 1 || c == 4) st.act = 1'b0;
        phy_stat <= st;
        repeat (3) @(posedge pclk);
        chk(lit[0], l0_on(c, st));
      end
      if (c == 10) chk(lamp_oe_n[0], 1'b1);
    end
    // forced blink at the fastest rate
    apb(1'b1, 8'h40, 32'hb);
    count(2100);
    chk(cnt >= 4 && cnt <= 6, 1'b1);
    // speed groups, none without link
    apb(1'b1, 8'h40, 32'h2);
    phy_stat <= '0;
    count(3000);
    chk(cnt, 0);
    for (int s = 0; s < 3; s++) begin
      phy_stat <= '{1'b1, 2'(s), 1'b0, 1'b0, 1'b1};
      count((2 * s + 3) * SPD - 100);
      chk(cnt, s + 1);
      phy_stat <= '0;
      count(20);
    end
    // dual mode with link: a full share moves the light to lamp 1
    phy_stat <= 6'h20;
    apb(1'b1, 8'h40, 32'hc);
    for (int m = 0; m < 9; m += 8) begin
      apb(1'b1, 8'h44, 32'(m << 8 | 5));
      repeat (2) @(posedge pclk);
      chk(lamp_out[1:0], (m > 0) ? 2'h2 : 2'h1);
    end
    // interrupt request, force and polarity in every combination
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'h48, {16'h0, i[1], 3'h0, i[0], 11'h0});
      irq_req <= i[2];
      repeat (3) @(posedge pclk);
      chk(phy_irq_out, (i[2] | i[1]) ^ i[0]);
    end
    summarize();
  end
endmodule
